// File: rtl/fsgc_pkg.sv
// Functional notes
// - in normal run select the higher peak limit level for peak trip.
// - in start-up select the lower peak limit level for peak trip.
// - ignore both trips for a blanking interval at each on-time start.
// - after blanking open a window; honour the ccm window trip only inside it.
// - a ccm window trip inside the window ends the current on-time.
// - the two trips are ORed to reset the on/off latch, ending the on-time.
// - start-up off-time is fixed; its expiry sets the latch for a new on-time unless the burst's 16 pulses are done.
// - in normal run both trips stay active with the same qualification.
// - in normal run a trip ends the on-time until the next command on edge.
// - in normal run without trips the gate follows the command exactly.
// - in start-up each burst period allows exactly 16 switching cycles.
// - burst period is a parameter covering 50 Hz to 1000 Hz.
// - the burst oscillator is disabled in normal run.
// - the pwm command input is active low.
// - without pwm activity for the timeout, return to start-up mode.
// - external commands drive the gate only while the linear regulator is off.
// - undervoltage holds the gate off in every mode.
`default_nettype none
package fsgc_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS     = 5;
  localparam int CNT_W      = 22;
  localparam int BLANK_NS   = 240;
  localparam int WIN_NS     = 166;
  localparam int OFF_NS     = 21000;
  localparam int TIMEOUT_NS = 260000;
  localparam int BURST_HZ   = 1000;
  localparam int BURST_HZ_MIN = 50;
  localparam int BURST_HZ_MAX = 1000;
  localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WIN_CYC   = CNT_W'(WIN_NS / CLK_NS);
  localparam logic [CNT_W-1:0] OFF_CYC_DEF = CNT_W'((OFF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] TIMEOUT_CYC_DEF =
    CNT_W'((TIMEOUT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] BURST_CYC_DEF = CNT_W'(1000000000 / (CLK_NS * BURST_HZ));
  localparam logic [4:0] BURST_PULSES = 5'h10;
  // ************************************************************
  // pin synchroniser: pwm_n, peak, ccm, hv_off, uvlo
  // ************************************************************
  localparam int NSYNC = 5;
  localparam logic [NSYNC-1:0] SYNC_RST = 5'h11;
  typedef enum logic {MD_STARTUP, MD_NORMAL} fsgc_mode_t;
endpackage
`default_nettype wire

// File: rtl/fsgc_qual.sv
`default_nettype none
module fsgc_qual
  import fsgc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  fsgc_qual_if.qual  q
);
  logic [CNT_W-1:0] on_cnt_q;
  logic             blank;
  logic             window;

  // ************************************************************
  // on-time counter
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt_q <= '0;
    end else if (!q.gate_on) begin
      on_cnt_q <= '0;
    end else if (on_cnt_q < BLANK_CYC + WIN_CYC) begin
      on_cnt_q <= on_cnt_q + 1'b1;
    end
  end

  assign blank  = on_cnt_q < BLANK_CYC;
  assign window = !blank && (on_cnt_q < BLANK_CYC + WIN_CYC);
  assign q.trip_rst = q.gate_on && !blank &&
                      (q.peak_trip || (window && q.ccm_trip));

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_blank_ignore: assert property (
    $rose(q.gate_on) |-> !q.trip_rst [*8])
    else $error("trip honoured during blanking");
  chk_window_only: assert property (
    (on_cnt_q >= BLANK_CYC + WIN_CYC) && !q.peak_trip |-> !q.trip_rst)
    else $error("ccm trip honoured outside window");
  chk_ccm_ends: assert property (
    q.gate_on && q.ccm_trip && (on_cnt_q >= BLANK_CYC) &&
    (on_cnt_q < BLANK_CYC + WIN_CYC) |-> q.trip_rst)
    else $error("ccm trip in window ignored");
endmodule
`default_nettype wire

// File: rtl/fsgc_qual_if.sv
`default_nettype none
interface fsgc_qual_if;
  logic gate_on;
  logic peak_trip;
  logic ccm_trip;
  logic trip_rst;
  modport ctl  (output gate_on, output peak_trip, output ccm_trip, input trip_rst);
  modport qual (input gate_on, input peak_trip, input ccm_trip, output trip_rst);
endinterface
`default_nettype wire

// File: rtl/fsgc_top.sv
`default_nettype none
module fsgc_top
  import fsgc_pkg::*;
#(
  parameter logic [CNT_W-1:0] OFF_CYC     = OFF_CYC_DEF,
  parameter logic [CNT_W-1:0] TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter logic [CNT_W-1:0] BURST_CYC   = BURST_CYC_DEF
)(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic EXT_PWM_CMD_N,
  input  wire logic PEAK_LIMIT_TRIP,
  input  wire logic CCM_WINDOW_TRIP,
  input  wire logic HV_REG_OFF,
  input  wire logic UVLO_LOW,
  output var  logic GATE,
  output var  logic PEAK_LIMIT_HIGH_SEL,
  output var  logic NORMAL_RUN,
  output var  logic BURST_ACTIVE
);
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] filt_q;
  logic             cmd_on;
  logic             cmd_on_prev_q;
  logic             cmd_rise;
  logic             pwm_edge;
  logic             hv_off;
  logic             uvlo;
  fsgc_mode_t       mode_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic [CNT_W-1:0] burst_cnt_q;
  logic [CNT_W-1:0] off_cnt_q;
  logic [4:0]       pulse_cnt_q;
  logic             latch_q;
  logic             block_q;
  logic             gate_q;
  logic             gate_d;
  logic             burst_act;
  logic             burst_start;
  logic             trip;
  logic             startup;

  fsgc_qual_if qi ();

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  assign pin_in = {EXT_PWM_CMD_N, PEAK_LIMIT_TRIP, CCM_WINDOW_TRIP, HV_REG_OFF, UVLO_LOW};

  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        s1_q[i]   <= SYNC_RST[i];
        s2_q[i]   <= SYNC_RST[i];
        s3_q[i]   <= SYNC_RST[i];
        filt_q[i] <= SYNC_RST[i];
      end else begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign cmd_on   = !filt_q[4];
  assign hv_off   = filt_q[1];
  assign uvlo     = filt_q[0];
  assign cmd_rise = cmd_on && !cmd_on_prev_q;
  assign pwm_edge = cmd_on != cmd_on_prev_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_on_prev_q <= 1'b0;
    end else begin
      cmd_on_prev_q <= cmd_on;
    end
  end

  // ************************************************************
  // mode selection
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q     <= MD_STARTUP;
      idle_cnt_q <= '0;
    end else if (uvlo || !hv_off) begin
      mode_q     <= MD_STARTUP;
      idle_cnt_q <= '0;
    end else if (pwm_edge) begin
      mode_q     <= MD_NORMAL;
      idle_cnt_q <= '0;
    end else if (mode_q == MD_NORMAL) begin
      if (idle_cnt_q >= TIMEOUT_CYC - 1'b1) begin
        mode_q     <= MD_STARTUP;
        idle_cnt_q <= '0;
      end else begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
    end
  end

  assign startup = (mode_q == MD_STARTUP);

  // ************************************************************
  // blanking and window qualification
  // ************************************************************
  assign qi.gate_on   = gate_q;
  assign qi.peak_trip = filt_q[3];
  assign qi.ccm_trip  = filt_q[2];
  assign trip         = qi.trip_rst;

  fsgc_qual u_qual (
    .clk   (CLK),
    .rst_n (RST_N),
    .q     (qi)
  );

  // ************************************************************
  // burst oscillator
  // ************************************************************
  assign burst_start = startup && !uvlo && (burst_cnt_q == '0);
  assign burst_act   = startup && (pulse_cnt_q < BURST_PULSES);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      burst_cnt_q <= '0;
    end else if (!startup || uvlo) begin
      burst_cnt_q <= '0;
    end else if (burst_cnt_q >= BURST_CYC - 1'b1) begin
      burst_cnt_q <= '0;
    end else begin
      burst_cnt_q <= burst_cnt_q + 1'b1;
    end
  end

  // ************************************************************
  // start-up current regulator
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_q     <= 1'b0;
      off_cnt_q   <= '0;
      pulse_cnt_q <= BURST_PULSES;
    end else if (!startup || uvlo) begin
      latch_q     <= 1'b0;
      off_cnt_q   <= '0;
      pulse_cnt_q <= BURST_PULSES;
    end else if (burst_start) begin
      latch_q     <= 1'b1;
      off_cnt_q   <= '0;
      pulse_cnt_q <= '0;
    end else if (burst_act) begin
      if (latch_q) begin
        if (trip) begin
          latch_q   <= 1'b0;
          off_cnt_q <= '0;
        end
      end else if (off_cnt_q >= OFF_CYC - 1'b1) begin
        off_cnt_q   <= '0;
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
        latch_q     <= (pulse_cnt_q + 1'b1) < BURST_PULSES;
      end else begin
        off_cnt_q <= off_cnt_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // normal run trip blocking
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      block_q <= 1'b0;
    end else if (startup) begin
      block_q <= 1'b0;
    end else if (trip) begin
      block_q <= 1'b1;
    end else if (cmd_rise) begin
      block_q <= 1'b0;
    end
  end

  // ************************************************************
  // gate driver
  // ************************************************************
  always_comb begin
    if (uvlo) begin
      gate_d = 1'b0;
    end else if (!startup) begin
      gate_d = hv_off && cmd_on && !block_q && !trip;
    end else begin
      gate_d = burst_act && latch_q && !trip;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign GATE                = gate_q;
  assign PEAK_LIMIT_HIGH_SEL = !startup;
  assign NORMAL_RUN          = !startup;
  assign BURST_ACTIVE        = burst_act;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_uvlo_gate_off: assert property (uvlo |=> !gate_q)
    else $error("gate on during undervoltage");
  chk_peak_level_sel: assert property (
    $rose(mode_q == MD_NORMAL) |-> PEAK_LIMIT_HIGH_SEL && !BURST_ACTIVE)
    else $error("peak level or burst wrong in normal run");
  chk_trip_ends_on: assert property (trip |=> !gate_q)
    else $error("trip did not end on-time");
  chk_block_until_edge: assert property (
    !startup && trip ##1 !cmd_rise && !startup |=> !gate_q)
    else $error("on-time restarted without command edge");
  chk_normal_follow: assert property (
    !startup && hv_off && !uvlo && cmd_on && !block_q && !trip |=> gate_q)
    else $error("gate did not follow command");
  chk_burst_count: assert property (pulse_cnt_q <= BURST_PULSES)
    else $error("burst pulse count overrun");
  chk_burst_off: assert property (!startup |-> !burst_act)
    else $error("burst active in normal run");
  chk_idle_gate_low: assert property (
    startup && !burst_act |=> !gate_q)
    else $error("gate on outside burst");
  chk_off_time: assert property (
    startup && $fell(gate_q) |-> !gate_q [*8])
    else $error("off-time too short");
endmodule
`default_nettype wire

// File: testbench/fsgc_sec_model.sv
`default_nettype none
module fsgc_sec_model (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] on_cyc,
  input  wire logic [15:0] off_cyc,
  output var  logic        pwm_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // secondary pwm source
  // ************************************************************
  int cnt;
  initial pwm_n = 1'b1;
  initial cnt = 0;
  always @(posedge clk) begin
    if (!en) begin
      pwm_n <= 1'b1; // idle at the pull-up level
      cnt   <= 0;
    end else begin
      pwm_n <= (cnt < int'(on_cyc)) ? 1'b0 : 1'b1; // low commands gate on
      cnt   <= (cnt == int'(on_cyc) + int'(off_cyc) - 1) ? 0 : cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module tb
  import fsgc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [CNT_W-1:0] T_OFF = 22'h14;
  localparam logic [CNT_W-1:0] T_TO  = 22'h258;
  localparam logic [CNT_W-1:0] T_BUR = 22'h7d0;
  logic        clk;
  logic        rst_n;
  logic        pwm_n;
  logic        peak;
  logic        ccm;
  logic        hv_off;
  logic        uvlo;
  logic        gate;
  logic        hi_sel;
  logic        norm;
  logic        burst;
  logic        sec_en;
  logic [15:0] sec_on;
  logic [15:0] sec_off;
  int          miscompares;
  int          tests_run;
  fsgc_top #(.OFF_CYC(T_OFF), .TIMEOUT_CYC(T_TO), .BURST_CYC(T_BUR)) dut_u (
    .CLK(clk), .RST_N(rst_n), .EXT_PWM_CMD_N(pwm_n), .PEAK_LIMIT_TRIP(peak),
    .CCM_WINDOW_TRIP(ccm), .HV_REG_OFF(hv_off), .UVLO_LOW(uvlo), .GATE(gate),
    .PEAK_LIMIT_HIGH_SEL(hi_sel), .NORMAL_RUN(norm), .BURST_ACTIVE(burst)
  );
  fsgc_sec_model sec_u (
    .clk(clk), .en(sec_en), .on_cyc(sec_on), .off_cyc(sec_off), .pwm_n(pwm_n)
  );
  always #2.5 clk = ~clk;
  // ************************************************************
  // helpers and scenarios
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (((sel == 0) ? gate : norm) !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        miscompares++;
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, ~lvl, lvl);
        tally_and_finish();
      end
    end
  endtask
  task automatic t_startup();
    int n;
    int k;
    int i;
    int tot;
    logic prev;
    @(posedge clk) uvlo <= 1'b0;
    peak <= 1'b1;
    wait_sig(0, 1'b1, 40, n);
    `CHK(hi_sel, 1'b0)
    `CHK(burst, 1'b1)
    wait_sig(0, 1'b0, 80, n);
    tot = n;
    `CHK(n >= 47 && n <= 53, 1'b1)
    wait_sig(0, 1'b1, 60, n);
    tot += n;
    `CHK(n >= int'(T_OFF) && n <= int'(T_OFF) + 3, 1'b1)
    k = 2;
    prev = 1'b1;
    for (i = 0; i < 2500 && burst === 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (gate === 1'b1 && prev === 1'b0) k++;
      prev = gate;
    end
    tot += i;
    @(posedge clk) peak <= 1'b0;
    tot += 1;
    `CHK(k, 16)
    k = 0;
    for (i = 0; i < 2500 && burst !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (gate !== 1'b0) k++;
    end
    tot += i;
    `CHK(k, 0)
    `CHK(burst, 1'b1)
    `CHK(tot, int'(T_BUR) - 1)
  endtask
  task automatic t_window();
    int n;
    wait_sig(0, 1'b1, 40, n);
    repeat (100) @(posedge clk);
    ccm <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    `CHK(gate, 1'b1)
    @(posedge clk) ccm <= 1'b0;
    peak <= 1'b1;
    wait_sig(0, 1'b0, 10, n);
    `CHK(gate, 1'b0)
    @(posedge clk) peak <= 1'b0;
    wait_sig(0, 1'b1, 60, n);
    repeat (50) @(posedge clk);
    ccm <= 1'b1;
    wait_sig(0, 1'b0, 12, n);
    `CHK(n <= 8, 1'b1)
    @(posedge clk) ccm <= 1'b0;
  endtask
  task automatic t_normal();
    int n;
    @(posedge clk) hv_off <= 1'b1;
    sec_on <= 16'h0096;
    sec_off <= 16'h0064;
    sec_en <= 1'b1;
    wait_sig(1, 1'b1, 400, n);
    @(posedge clk);
    #1;
    `CHK(hi_sel, 1'b1)
    `CHK(burst, 1'b0)
    wait_sig(0, 1'b0, 400, n);
    wait_sig(0, 1'b1, 400, n);
    wait_sig(0, 1'b0, 400, n);
    `CHK(n, 150)
    wait_sig(0, 1'b1, 400, n);
    `CHK(n, 100)
    repeat (70) @(posedge clk);
    peak <= 1'b1;
    wait_sig(0, 1'b0, 10, n);
    `CHK(n <= 8, 1'b1)
    @(posedge clk) peak <= 1'b0;
    wait_sig(0, 1'b1, 400, n);
    `CHK(n >= 150, 1'b1)
  endtask
  task automatic t_timeout();
    int n;
    @(posedge clk) sec_en <= 1'b0;
    wait_sig(1, 1'b0, int'(T_TO) + 50, n);
    `CHK(n >= int'(T_TO) - 260 && n <= int'(T_TO) + 20, 1'b1)
    `CHK(hi_sel, 1'b0)
  endtask
  task automatic t_guard();
    int n;
    int k;
    @(posedge clk) sec_en <= 1'b1;
    hv_off <= 1'b0;
    k = 0;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (norm !== 1'b0) k++;
    end
    `CHK(k, 0)
    @(posedge clk) hv_off <= 1'b1;
    wait_sig(1, 1'b1, 400, n);
    @(posedge clk) uvlo <= 1'b1;
    repeat (10) @(posedge clk);
    k = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (gate !== 1'b0) k++;
    end
    `CHK(k, 0)
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    peak = 1'b0;
    ccm = 1'b0;
    hv_off = 1'b0;
    uvlo = 1'b1;
    sec_en = 1'b0;
    sec_on = 16'h0000;
    sec_off = 16'h0000;
    miscompares = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    #1;
    `CHK({gate, hi_sel, norm, burst}, 4'h0)
    @(posedge clk) rst_n <= 1'b1;
    t_startup();
    t_window();
    t_normal();
    t_timeout();
    t_guard();
    tally_and_finish();
  end
endmodule
`default_nettype wire
